// >>> design/adc_serial_control_sequencer.sv
`timescale 1ns/100ps

// Notes on behaviour
// - Shift one input bit per rising clock
// - Leading zeros ignored; first one starts byte, but ones are ignored for eight clocks after a byte
// - Single-ended: channel positive, common pin negative
// - Differential: only fixed pairs 0/1..6/7
// - Single-ended codes map channels 0,2,4,6,1,3,5,7
// - Differential codes 1xx swap pair polarity
// - Track starts falling edge after fifth bit
// - Hold starts falling edge after eighth bit
// - Conversion end reconnects positive input, tracking
// - Strobe high one period before result MSB
// - Sixteen clocks per conversion in total
// - Strobe and data change on rising edges
// - Control byte fields: start, select, polarity, config
// - Lowest two bits select the power mode
// - Result: three zeros, ten bits, two, zero
// - Unipolar straight binary, bipolar two's complement
module adc_serial_control_sequencer
  import adc_serial_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        DIN,
  output logic             DOUT_O,
  output logic             DOUT_OE,
  output logic             CONVERSION_STROBE_OUT,
  output logic             CONVERSION_STROBE_OE,
  input  wire logic [11:0] SAMPLE_CODE,
  output logic [2:0]       POS_CHANNEL,
  output logic [2:0]       NEG_CHANNEL,
  output logic             NEG_TO_COM,
  output logic             UNIPOLAR,
  output logic [1:0]       POWER_MODE,
  output logic             LOW_POWER,
  output logic             HOLD_CAPACITOR_TRACK,
  output logic             CONV_BUSY
);

  typedef struct packed {
    logic [6:0]  shift_in;
    logic [3:0]  in_cnt;
    ctrl_byte_s  ctrl;
    logic        ctrl_tgl;
    logic [15:0] out_sh;
    logic [4:0]  out_cnt;
    logic        dout;
    logic        strobe;
    logic        done;
    logic        busy;
    logic        res_req_s1;
    logic        res_req_s2;
    logic        res_ack;
    logic [11:0] res_word;
  } rise_s;

  typedef struct packed {
    logic hold;
  } fall_s;

  typedef struct packed {
    logic        ctrl_t1;
    logic        ctrl_t2;
    logic        ctrl_t3;
    ctrl_byte_s  ctrl_cap;
    logic [2:0]  pos_ch;
    logic [2:0]  neg_ch;
    logic        neg_com;
    logic        res_req;
    logic [11:0] res_hold;
    logic        ack_s1;
    logic        ack_s2;
    logic        hold_s1;
    logic        hold_s2;
    logic        busy_s1;
    logic        busy_s2;
    logic        low_power;
  } ref_s;

  rise_s r_ff;
  rise_s nxt_r;
  fall_s f_ff;
  fall_s nxt_f;
  ref_s  ref_ff;
  ref_s  nxt_ref;

  function automatic logic [2:0] chan_pos(input logic [2:0] sel);
    chan_pos = {sel[1:0], sel[2]};
  endfunction

  function automatic logic [2:0] chan_neg(input logic [2:0] sel);
    chan_neg = {sel[1:0], ~sel[2]};
  endfunction

  function automatic logic [15:0] result_frame(input logic [11:0] w,
                                               input logic        uni);
    logic [RESULT_BITS-1:0] code;
    code = w[CODE_BITS-1:SUB_LSB_BITS];
    if (!uni) begin
      code[RESULT_BITS-1] = ~code[RESULT_BITS-1];
    end
    result_frame = {{LEAD_ZEROS{1'b0}}, code, w[SUB_LSB_BITS-1:0], 1'b0};
  endfunction

  logic        hunt_ok;
  ctrl_byte_s  new_byte;
  logic [15:0] frame;
  logic [1:0]  ref_rst_ff;
  logic        ref_rst;

  // Serial side, rising edges of the link clock.
  always_comb begin
    nxt_r      = r_ff;
    nxt_r.done = 1'b0;
    nxt_r.strobe = 1'b0;
    new_byte   = {r_ff.shift_in, DIN};
    frame      = result_frame(r_ff.res_word,
                              new_byte[CTRL_POS_POLARITY]);
    hunt_ok    = (r_ff.out_cnt == 5'h00) || (r_ff.out_cnt >= HUNT_SLOT);

    nxt_r.res_req_s1 = ref_ff.res_req;
    nxt_r.res_req_s2 = r_ff.res_req_s1;
    if (r_ff.res_req_s2 != r_ff.res_ack) begin
      nxt_r.res_word = ref_ff.res_hold;
      nxt_r.res_ack  = r_ff.res_req_s2;
    end

    if (r_ff.out_cnt != 5'h00) begin
      if (r_ff.out_cnt == FRAME_BITS) begin
        nxt_r.dout    = 1'b0;
        nxt_r.out_cnt = 5'h00;
        nxt_r.done    = 1'b1;
        nxt_r.busy    = 1'b0;
      end else begin
        nxt_r.dout    = r_ff.out_sh[15];
        nxt_r.out_sh  = {r_ff.out_sh[14:0], 1'b0};
        nxt_r.out_cnt = r_ff.out_cnt + 5'h01;
      end
      if (r_ff.out_cnt == STROBE_SLOT) begin
        nxt_r.strobe = 1'b1;
      end
    end

    if (!CS_N) begin
      if (r_ff.in_cnt == 4'h0) begin
        if (DIN && hunt_ok) begin
          nxt_r.shift_in = START_SEED;
          nxt_r.in_cnt   = 4'h1;
        end
      end else if (r_ff.in_cnt == CTRL_BITS) begin
        nxt_r.in_cnt = 4'h0;
      end else begin
        nxt_r.shift_in = {r_ff.shift_in[5:0], DIN};
        nxt_r.in_cnt   = r_ff.in_cnt + 4'h1;
        if (r_ff.in_cnt == CTRL_LAST_SHIFT) begin
          nxt_r.ctrl     = new_byte;
          nxt_r.ctrl_tgl = ~r_ff.ctrl_tgl;
          nxt_r.busy     = 1'b1;
          nxt_r.dout     = frame[15];
          nxt_r.out_sh   = {frame[14:0], 1'b0};
          nxt_r.out_cnt  = 5'h01;
          nxt_r.strobe   = 1'b0;
        end
      end
    end else begin
      nxt_r.in_cnt = 4'h0;
    end
  end

  always_ff @(posedge SCLK or posedge RESET) begin
    if (RESET) begin
      r_ff <= '{shift_in:   7'h00,
                in_cnt:     4'h0,
                ctrl:       CTRL_RESET,
                ctrl_tgl:   1'b0,
                out_sh:     16'h0000,
                out_cnt:    5'h00,
                dout:       1'b0,
                strobe:     1'b0,
                done:       1'b0,
                busy:       1'b0,
                res_req_s1: 1'b0,
                res_req_s2: 1'b0,
                res_ack:    1'b0,
                res_word:   CODE_RESET};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Track/hold switch, falling edges of the link clock.
  always_comb begin
    nxt_f = f_ff;
    if (r_ff.in_cnt == CTRL_BITS) begin
      nxt_f.hold = 1'b1;
    end else if (r_ff.done) begin
      nxt_f.hold = 1'b0;
    end else if (r_ff.in_cnt == TRACK_AT_BIT) begin
      nxt_f.hold = 1'b0;
    end
  end

  always_ff @(negedge SCLK or posedge RESET) begin
    if (RESET) begin
      f_ff <= '{hold: 1'b0};
    end else begin
      f_ff <= nxt_f;
    end
  end

  // Reset leaves the core domain in step with its own clock.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      ref_rst_ff <= 2'h3;
    end else begin
      ref_rst_ff <= {ref_rst_ff[0], 1'h0};
    end
  end

  assign ref_rst = ref_rst_ff[1];

  // Core side on the reference clock: mux selects and sample hand-off.
  always_comb begin
    nxt_ref         = ref_ff;
    nxt_ref.ctrl_t1 = r_ff.ctrl_tgl;
    nxt_ref.ctrl_t2 = ref_ff.ctrl_t1;
    nxt_ref.ctrl_t3 = ref_ff.ctrl_t2;
    nxt_ref.ack_s1  = r_ff.res_ack;
    nxt_ref.ack_s2  = ref_ff.ack_s1;
    nxt_ref.hold_s1 = f_ff.hold;
    nxt_ref.hold_s2 = ref_ff.hold_s1;
    nxt_ref.busy_s1 = r_ff.busy;
    nxt_ref.busy_s2 = ref_ff.busy_s1;

    if (ref_ff.ctrl_t2 != ref_ff.ctrl_t3) begin
      nxt_ref.ctrl_cap = r_ff.ctrl;
      nxt_ref.pos_ch   = chan_pos({r_ff.ctrl.channel_select_msb,
                                   r_ff.ctrl.channel_select_mid,
                                   r_ff.ctrl.channel_select_lsb});
      nxt_ref.neg_ch   = chan_neg({r_ff.ctrl.channel_select_msb,
                                   r_ff.ctrl.channel_select_mid,
                                   r_ff.ctrl.channel_select_lsb});
      nxt_ref.neg_com  = r_ff.ctrl.input_config_select;
    end

    if (ref_ff.res_req == ref_ff.ack_s2) begin
      nxt_ref.res_hold = SAMPLE_CODE;
      nxt_ref.res_req  = ~ref_ff.res_req;
    end

    nxt_ref.low_power = !ref_ff.busy_s2 &&
      ({ref_ff.ctrl_cap.power_mode_hi, ref_ff.ctrl_cap.power_mode_lo}
       != PWR_NORMAL);
  end

  always_ff @(posedge REF_CLK or posedge ref_rst) begin
    if (ref_rst) begin
      ref_ff <= '{ctrl_t1:   1'b0,
                  ctrl_t2:   1'b0,
                  ctrl_t3:   1'b0,
                  ctrl_cap:  CTRL_RESET,
                  pos_ch:    3'h7,
                  neg_ch:    3'h6,
                  neg_com:   1'b1,
                  res_req:   1'b0,
                  res_hold:  CODE_RESET,
                  ack_s1:    1'b0,
                  ack_s2:    1'b0,
                  hold_s1:   1'b0,
                  hold_s2:   1'b0,
                  busy_s1:   1'b0,
                  busy_s2:   1'b0,
                  low_power: 1'b0};
    end else begin
      ref_ff <= nxt_ref;
    end
  end

  assign DOUT_O                = r_ff.dout;
  assign DOUT_OE               = !CS_N;
  assign CONVERSION_STROBE_OUT = r_ff.strobe;
  assign CONVERSION_STROBE_OE  = !CS_N;
  assign POS_CHANNEL           = ref_ff.pos_ch;
  assign NEG_CHANNEL           = ref_ff.neg_ch;
  assign NEG_TO_COM            = ref_ff.neg_com;
  assign UNIPOLAR              = ref_ff.ctrl_cap.polarity_select;
  assign POWER_MODE            = {ref_ff.ctrl_cap.power_mode_hi,
                                  ref_ff.ctrl_cap.power_mode_lo};
  assign LOW_POWER             = ref_ff.low_power;
  assign HOLD_CAPACITOR_TRACK  = !ref_ff.hold_s2;
  assign CONV_BUSY             = ref_ff.busy_s2;

endmodule

// >>> common/adc_serial_pkg.sv
package adc_serial_pkg;

  typedef enum logic [1:0] {
    PWR_FULL_DOWN,
    PWR_FAST_DOWN,
    PWR_REDUCED,
    PWR_NORMAL
  } power_mode_e;

  typedef struct packed {
    logic start;
    logic channel_select_msb;
    logic channel_select_mid;
    logic channel_select_lsb;
    logic polarity_select;
    logic input_config_select;
    logic power_mode_hi;
    logic power_mode_lo;
  } ctrl_byte_s;

  localparam int        CTRL_POS_START    = 7;
  localparam int        CTRL_POS_POLARITY = 3;
  localparam logic [3:0] CTRL_BITS        = 4'h8;
  localparam logic [3:0] CTRL_LAST_SHIFT  = 4'h7;
  localparam logic [3:0] TRACK_AT_BIT     = 4'h5;
  localparam logic [4:0] FRAME_BITS       = 5'h10;
  localparam logic [4:0] STROBE_SLOT      = 5'h02;
  localparam logic [4:0] HUNT_SLOT        = 5'h09;
  localparam int        LEAD_ZEROS        = 3;
  localparam int        RESULT_BITS       = 10;
  localparam int        SUB_LSB_BITS      = 2;
  localparam int        CODE_BITS         = 12;
  localparam logic [6:0] START_SEED       = 7'h01;
  localparam ctrl_byte_s CTRL_RESET       = 8'hff;
  localparam logic [11:0] CODE_RESET      = 12'h000;

endpackage

// >>> tb/adc_serial_chk.sv
`timescale 1ns/100ps
module adc_serial_chk (
  input wire logic       REF_CLK,
  input wire logic       RESET,
  input wire logic       SCLK,
  input wire logic       DOUT_O,
  input wire logic       CONVERSION_STROBE_OUT,
  input wire logic [2:0] POS_CHANNEL,
  input wire logic [2:0] NEG_CHANNEL,
  input wire logic       NEG_TO_COM,
  input wire logic [1:0] POWER_MODE,
  input wire logic       LOW_POWER,
  input wire logic       HOLD_CAPACITOR_TRACK,
  input wire logic       CONV_BUSY
);
  a_strobe_single: assert property (@(posedge SCLK) disable iff (RESET)
    $rose(CONVERSION_STROBE_OUT) |=> !CONVERSION_STROBE_OUT)
    else $error("strobe high longer than one period");
  a_strobe_lead: assert property (@(posedge SCLK) disable iff (RESET)
    $rose(CONVERSION_STROBE_OUT) |-> !DOUT_O && !$past(DOUT_O))
    else $error("leading result bits not zero");
  a_strobe_space: assert property (@(posedge SCLK) disable iff (RESET)
    $rose(CONVERSION_STROBE_OUT) |=> (!CONVERSION_STROBE_OUT) [*8])
    else $error("strobes too close together");
  a_neg_pair: assert property (@(posedge REF_CLK) disable iff (RESET)
    !NEG_TO_COM |-> NEG_CHANNEL == {POS_CHANNEL[2:1], ~POS_CHANNEL[0]})
    else $error("negative input outside its pair");
  a_busy_full: assert property (@(posedge REF_CLK) disable iff (RESET)
    CONV_BUSY [*2] |-> !LOW_POWER)
    else $error("low power during conversion");
  a_idle_low: assert property (@(posedge REF_CLK) disable iff (RESET)
    (!CONV_BUSY && POWER_MODE != 2'h3) [*3] |-> LOW_POWER)
    else $error("idle power mode not honoured");
  a_normal_full: assert property (@(posedge REF_CLK) disable iff (RESET)
    (POWER_MODE == 2'h3) [*2] |-> !LOW_POWER)
    else $error("low power in normal mode");
  a_track_idle: assert property (@(posedge REF_CLK) disable iff (RESET)
    (!CONV_BUSY) [*4] |-> HOLD_CAPACITOR_TRACK)
    else $error("not tracking while idle");
endmodule
bind adc_serial_control_sequencer adc_serial_chk i_chk (
  .REF_CLK(REF_CLK), .RESET(RESET), .SCLK(SCLK), .DOUT_O(DOUT_O),
  .CONVERSION_STROBE_OUT(CONVERSION_STROBE_OUT), .POS_CHANNEL(POS_CHANNEL),
  .NEG_CHANNEL(NEG_CHANNEL), .NEG_TO_COM(NEG_TO_COM),
  .POWER_MODE(POWER_MODE), .LOW_POWER(LOW_POWER), .CONV_BUSY(CONV_BUSY),
  .HOLD_CAPACITOR_TRACK(HOLD_CAPACITOR_TRACK));

// >>> tb/host_master.sv
`timescale 1ns/100ps
module host_master (
  output logic      SCLK,
  output logic      CS_N,
  output logic      DIN,
  input  wire logic DOUT_O,
  input  wire logic DOUT_OE
);
  logic last_q;
  logic dout_w;
  assign dout_w = DOUT_OE ? DOUT_O : last_q;
  always @(negedge DOUT_OE) last_q = ~DOUT_O;
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
    DIN = 1'b0;
    last_q = 1'b0;
  end
  // Clock idles low, data changes after the fall, sampled at the rise.
  task automatic shift(input logic tx, output logic rx);
    DIN <= tx;
    #6 rx = dout_w;
    SCLK = 1'b1;
    #6 SCLK = 1'b0;
  endtask
  task automatic frame(input int lead, input logic [7:0] ctrl,
                       output logic [15:0] res);
    logic r;
    CS_N <= 1'b0;
    #6;
    repeat (lead) shift(1'b0, r);
    for (int i = 7; i >= 0; i--) shift(ctrl[i], r);
    for (int i = 15; i >= 0; i--) begin
      shift(1'b0, r);
      res[i] = r;
    end
    #6 CS_N <= 1'b1;
    #20;
  endtask
  task automatic stream(input int n);
    logic r;
    CS_N <= 1'b0;
    #6;
    repeat (16) shift(1'b0, r);
    repeat (n) shift(1'b1, r);
    repeat (16) shift(1'b0, r);
    #6 CS_N <= 1'b1;
    #20;
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import adc_serial_pkg::*;
  logic        REF_CLK, RESET, SCLK, CS_N, DIN, DOUT_O, DOUT_OE;
  logic        CONVERSION_STROBE_OUT, CONVERSION_STROBE_OE, NEG_TO_COM;
  logic        UNIPOLAR, LOW_POWER, HOLD_CAPACITOR_TRACK, CONV_BUSY;
  logic [11:0] SAMPLE_CODE, code;
  logic [2:0]  POS_CHANNEL, NEG_CHANNEL, c;
  logic [1:0]  POWER_MODE, pm;
  logic [15:0] res;
  logic        saw_hold, uni, sgl;
  int          fail_count, comparisons, cycles, span, period;
  adc_serial_control_sequencer i_dut (
    .REF_CLK(REF_CLK), .RESET(RESET), .SCLK(SCLK), .CS_N(CS_N),
    .DIN(DIN), .DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE),
    .CONVERSION_STROBE_OUT(CONVERSION_STROBE_OUT),
    .CONVERSION_STROBE_OE(CONVERSION_STROBE_OE), .SAMPLE_CODE(SAMPLE_CODE),
    .POS_CHANNEL(POS_CHANNEL), .NEG_CHANNEL(NEG_CHANNEL),
    .NEG_TO_COM(NEG_TO_COM), .UNIPOLAR(UNIPOLAR), .POWER_MODE(POWER_MODE),
    .LOW_POWER(LOW_POWER), .HOLD_CAPACITOR_TRACK(HOLD_CAPACITOR_TRACK),
    .CONV_BUSY(CONV_BUSY));
  host_master i_host (.SCLK(SCLK), .CS_N(CS_N), .DIN(DIN),
    .DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE));
  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end
  task automatic check(input string name, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(negedge SCLK) begin
    if (CONVERSION_STROBE_OUT === 1'b1) begin
      period <= span;
      span   <= 1;
    end else begin
      span <= span + 1;
    end
  end
  always @(posedge REF_CLK) begin
    cycles++;
    if (HOLD_CAPACITOR_TRACK === 1'b0) saw_hold <= 1'b1;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    RESET = 1'b1;
    SAMPLE_CODE = 12'h000;
    saw_hold = 1'b0;
    repeat (12) @(posedge REF_CLK);
    RESET <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    for (int k = 0; k < 16; k++) begin
      c = k[2:0];
      sgl = k[3];
      uni = k[0] ^ k[3];
      pm = k[1:0];
      code = {k[3:0], ~k[3:0], k[1:0], 2'h1};
      @(posedge REF_CLK) SAMPLE_CODE <= code;
      repeat (2) i_host.frame(k % 4, {1'b1, c, uni, sgl, pm}, res);
      repeat (8) @(posedge REF_CLK);
      check("result", res, {3'h0, code[11] ^ !uni, code[10:0], 1'b0});
      check("pos", 16'(POS_CHANNEL), 16'(c[1:0] * 2 + c[2]));
      check("neg_to_com", 16'(NEG_TO_COM), 16'(sgl));
      if (!sgl) check("neg", 16'(NEG_CHANNEL), 16'(c[1:0] * 2 + !c[2]));
      check("polarity", 16'(UNIPOLAR), 16'(uni));
      check("power", 16'(POWER_MODE), 16'(pm));
      check("low_power", 16'(LOW_POWER), 16'(pm != 2'h3));
      check("track", 16'(HOLD_CAPACITOR_TRACK), 16'h1);
      check("busy", 16'(CONV_BUSY), 16'h0);
      check("enables", 16'({DOUT_OE, CONVERSION_STROBE_OE}), 16'h0);
    end
    check("hold", 16'(saw_hold), 16'h1);
    $display("Test channel sweep done");
    i_host.stream(64);
    repeat (8) @(posedge REF_CLK);
    check("ones pos", 16'(POS_CHANNEL), 16'h7);
    check("ones low", 16'(LOW_POWER), 16'h0);
    check("ones period", 16'(period), 16'h0010);
    check("ones track", 16'(HOLD_CAPACITOR_TRACK), 16'h1);
    check("ones busy", 16'(CONV_BUSY), 16'h0);
    $display("Test quick look done");
    close_out();
  end
endmodule
